// ===== inc/plc_link_pkg.sv
// Constants, codes and timing for the programless PLC link engine.
// Assumes a single 25 MHz clock; no tool-specific features.
package plc_link_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned ONEN_TMO_S      = 30;
    localparam int unsigned FMT5_WAIT_MULT  = 3;
    localparam int unsigned FMT5_WAIT_DEF_S = 2;
    localparam int unsigned ONEN_TMO_CYC    = ONEN_TMO_S * CLK_HZ;
    localparam int unsigned FMT5_TMO_CYC    =
        FMT5_WAIT_MULT * FMT5_WAIT_DEF_S * CLK_HZ;

    localparam logic [15:0] RSP_IDLE        = 16'h0000;
    localparam logic [15:0] RSP_ERR_SINGLE  = 16'h8001;
    localparam logic [15:0] RSP_ERR_MULTI   = 16'h8002;
    localparam logic [15:0] RSP_ERR_BIT_S   = 16'h8003;
    localparam logic [15:0] RSP_ERR_BIT_M   = 16'h8004;
    localparam logic [15:0] RSP_LINK_ERR    = 16'hEEEE;
    localparam logic [15:0] REQ_CANCEL      = 16'hFFFF;
    localparam logic [15:0] REQ_STOP        = 16'h0000;

    localparam int unsigned MAX_GATEWAYS    = 8;
    localparam int unsigned MAX_SUBUNITS    = 32;
    localparam logic [5:0]  UNIT_BASE_LOW   = 6'h00;
    localparam logic [5:0]  UNIT_BASE_HIGH  = 6'h20;

    // Register offsets of the plain software port
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_READREQ  = 4'h1;
    localparam logic [3:0] REG_SETREQ   = 4'h2;
    localparam logic [3:0] REG_OPREQ    = 4'h3;
    localparam logic [3:0] REG_READRSP  = 4'h4;
    localparam logic [3:0] REG_SETRSP   = 4'h5;
    localparam logic [3:0] REG_OPRSP    = 4'h6;
    localparam logic [3:0] REG_STATUS   = 4'h7;
    localparam logic [3:0] REG_WAITTIME = 4'h8;

    // CTRL fields
    localparam int CTRL_PROTO_BIT   = 0;  // 0 one-to-N link, 1 format 5
    localparam int CTRL_LEGACY_BIT  = 1;  // earlier firmware revision
    localparam int CTRL_STOPSEL_BIT = 2;  // 1 = stop on link error
    localparam int CTRL_HIGHRNG_BIT = 3;  // upper unit range
    localparam int CTRL_MAXU_LSB    = 4;  // 3-bit maximum unit number
    localparam int CTRL_MYU_LSB     = 8;  // 3-bit own unit slot
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] WAIT_RESET = 16'd2;

    typedef enum logic [1:0] {
        OP_NONE   = 2'b00,
        OP_SINGLE = 2'b01,
        OP_MULTI  = 2'b10
    } req_form_t;

    typedef enum logic [1:0] {
        LNK_RUN    = 2'b00,
        LNK_HALTED = 2'b01,
        LNK_CANCEL = 2'b10
    } link_state_t;
endpackage

// ===== inc/link_timer_if.sv
// Interface between the engine and its timeout and turn-taking helpers.
// Assumes all parties sit on one clock.
`timescale 1ns/1ps
`default_nettype none
interface link_timer_if;
    logic        activity;
    logic        format5;
    logic [15:0] waitSec;
    logic        timeout;
    logic [2:0]  maxUnit;
    logic [2:0]  myUnit;
    logic        tokenIn;
    logic        myTurn;
    logic        turnDone;
    logic [2:0]  slot;
    modport engine (output activity, format5, waitSec, maxUnit, myUnit,
                    tokenIn, turnDone, input timeout, myTurn, slot);
    modport timer  (input activity, format5, waitSec, output timeout);
    modport turn   (input maxUnit, myUnit, tokenIn, turnDone,
                    output myTurn, slot);
endinterface
`default_nettype wire

// ===== hdl/link_watchdog.sv
// Link-loss watchdog: restarts on every PLC exchange.
// Assumes activity comes from the engine on the same clock: an exchange pulse, or high while not running.
`timescale 1ns/1ps
`default_nettype none
module link_watchdog
    import plc_link_pkg::*;
#(
    parameter int unsigned NT_CYC  = ONEN_TMO_CYC,
    parameter int unsigned SEC_CYC = CLK_HZ
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Engine side
    link_timer_if.timer tif
);
    logic [31:0] cntQ;
    logic [31:0] limit;

    // Format 5: wait time times three, huge waits wrap the 32-bit product; else NT_CYC
    always_comb begin
        if (tif.format5)
            limit = 32'(FMT5_WAIT_MULT) * 32'(tif.waitSec) * 32'(SEC_CYC);
        else
            limit = 32'(NT_CYC);
    end

    always_ff @(posedge clk) begin
        if (!rst_n || tif.activity)
            cntQ <= 32'h0000_0000;
        else if (cntQ < limit)
            cntQ <= cntQ + 32'h0000_0001;
    end

    assign tif.timeout = (cntQ >= limit) && !tif.activity;
endmodule // link_watchdog
`default_nettype wire

// ===== hdl/gateway_turn.sv
// Round-robin slot tracker for gateways sharing one PLC port.
// Assumes tokenIn pulses when any other gateway ends its turn on the line.
`timescale 1ns/1ps
`default_nettype none
module gateway_turn
    import plc_link_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Engine side
    link_timer_if.turn tif
);
    logic [2:0] slotQ;

    // Power-on starts at slot 0; a dead peer's slot holds until tokenIn pulses
    always_ff @(posedge clk) begin
        if (!rst_n)
            slotQ <= 3'h0;
        else if (tif.tokenIn || tif.turnDone) begin
            if (slotQ >= tif.maxUnit)
                slotQ <= 3'h0;
            else
                slotQ <= slotQ + 3'h1;
        end
    end

    assign tif.slot   = slotQ;
    assign tif.myTurn = (slotQ == tif.myUnit);
endmodule // gateway_turn
`default_nettype wire

// ===== hdl/plc_link_error_handshake.sv
// Programless request/response engine with error and cancel handshake.
// Assumes the PLC side presents request words and an exchange strobe.
`timescale 1ns/1ps
`default_nettype none
module plc_link_error_handshake
    import plc_link_pkg::*;
#(
    parameter int unsigned NT_CYC  = ONEN_TMO_CYC,
    parameter int unsigned SEC_CYC = CLK_HZ,
    parameter int unsigned UNITS   = MAX_SUBUNITS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Software register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    // PLC exchange pins (asynchronous)
    input  wire logic        plcExchange,
    input  wire logic        plcPowerGood,
    input  wire logic        lineToken,
    // Request qualification from the parameter store
    input  wire logic [4:0]  reqUnit,
    input  wire logic        reqMulti,
    input  wire logic        reqBitSpec,
    input  wire logic        valueInRange,
    input  wire logic        settingLocked,
    input  wire logic [UNITS-1:0] unitPresent,
    // Status out
    output logic             opExecute,
    output logic             linkHalted,
    output logic             myTurn,
    output logic [5:0]       activeUnit
);
    link_timer_if tif ();

    link_watchdog #(
        .NT_CYC  (NT_CYC),
        .SEC_CYC (SEC_CYC)
    ) uWatchdog (
        .clk   (clk),
        .rst_n (rst_n),
        .tif   (tif.timer)
    );

    gateway_turn uTurn (
        .clk   (clk),
        .rst_n (rst_n),
        .tif   (tif.turn)
    );

    // Two-flop synchronisers for pins
    logic [2:0] syncA_q;
    logic [2:0] syncB_q;
    logic       exchPrev_q;
    logic       tokPrev_q;
    logic       pwrPrev_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA_q <= 3'h0;
            syncB_q <= 3'h0;
        end else begin
            syncA_q <= {lineToken, plcPowerGood, plcExchange};
            syncB_q <= syncA_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            exchPrev_q <= 1'b0;
            tokPrev_q  <= 1'b0;
            pwrPrev_q  <= 1'b0;
        end else begin
            exchPrev_q <= syncB_q[0];
            pwrPrev_q  <= syncB_q[1];
            tokPrev_q  <= syncB_q[2];
        end
    end

    logic exchPulse;
    logic tokPulse;
    logic powerBack;
    assign exchPulse = syncB_q[0] && !exchPrev_q;
    assign tokPulse  = syncB_q[2] && !tokPrev_q;
    assign powerBack = syncB_q[1] && !pwrPrev_q;

    // Software registers
    logic [15:0] ctrl_q;
    logic [15:0] wait_q;
    logic [15:0] readReq_q;
    logic [15:0] setReq_q;
    logic [15:0] opReq_q;
    logic [15:0] readRsp_q;
    logic [15:0] setRsp_q;
    logic [15:0] opRsp_q;
    logic        powerLoss_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q    <= CTRL_RESET;
            wait_q    <= WAIT_RESET;
            readReq_q <= REQ_STOP;
            setReq_q  <= REQ_STOP;
            opReq_q   <= REQ_STOP;
        end else if (regWr) begin
            unique case (regAddr)
                REG_CTRL:     ctrl_q    <= regWdata;
                REG_WAITTIME: wait_q    <= regWdata;
                REG_READREQ:  readReq_q <= regWdata;
                REG_SETREQ:   setReq_q  <= regWdata;
                REG_OPREQ:    opReq_q   <= regWdata;
                default: ;
            endcase
        end
    end

    logic       proto5;
    logic       legacy;
    logic       stopSel;
    logic       highRange;
    assign proto5    = ctrl_q[CTRL_PROTO_BIT];
    assign legacy    = ctrl_q[CTRL_LEGACY_BIT];
    assign stopSel   = ctrl_q[CTRL_STOPSEL_BIT];
    assign highRange = ctrl_q[CTRL_HIGHRNG_BIT];

    assign tif.activity = exchPulse || lnk_q != LNK_RUN;
    assign tif.format5  = proto5;
    assign tif.waitSec  = wait_q;
    assign tif.maxUnit  = ctrl_q[CTRL_MAXU_LSB +: 3];
    assign tif.myUnit   = ctrl_q[CTRL_MYU_LSB +: 3];
    assign tif.tokenIn  = tokPulse;

    // Link state machine
    link_state_t lnk_q;
    logic        linkErr;
    logic        haltOnErr;
    assign linkErr   = tif.timeout && lnk_q == LNK_RUN;
    assign haltOnErr = !legacy || stopSel;

    always_ff @(posedge clk) begin
        if (!rst_n)
            lnk_q <= LNK_RUN;
        else begin
            unique case (lnk_q)
                LNK_RUN:
                    if (linkErr && haltOnErr)
                        lnk_q <= LNK_HALTED;
                LNK_HALTED:
                    if (opReq_q == REQ_CANCEL)
                        lnk_q <= LNK_CANCEL;
                    else if (powerLoss_q && powerBack && !proto5)
                        lnk_q <= LNK_RUN;
                LNK_CANCEL:
                    if (opReq_q == REQ_STOP)
                        lnk_q <= LNK_RUN;
                default:
                    lnk_q <= LNK_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            powerLoss_q <= 1'b0;
        else if (lnk_q == LNK_RUN && linkErr)
            powerLoss_q <= !syncB_q[1];
        else if (lnk_q == LNK_RUN)
            powerLoss_q <= 1'b0;
    end

    // Request qualification
    logic accessErr;
    logic service;
    assign accessErr = !valueInRange || !unitPresent[reqUnit]
                       || settingLocked;
    // Requests resume after cancel even before opReq returns to 0000
    assign service = exchPulse && tif.myTurn && lnk_q != LNK_HALTED;

    function automatic logic [15:0] errCode(input logic multi,
                                            input logic bitSpec);
        if (bitSpec)
            errCode = multi ? RSP_ERR_BIT_M : RSP_ERR_BIT_S;
        else
            errCode = multi ? RSP_ERR_MULTI : RSP_ERR_SINGLE;
    endfunction

    // Read and setting responses; errors stick until request stops
    always_ff @(posedge clk) begin
        if (!rst_n)
            readRsp_q <= RSP_IDLE;
        else if (readReq_q == REQ_STOP)
            readRsp_q <= RSP_IDLE;
        else if (service && readRsp_q[15:12] != 4'h8)
            readRsp_q <= accessErr ? errCode(reqMulti, 1'b0) : readReq_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            setRsp_q <= RSP_IDLE;
        else if (setReq_q == REQ_STOP)
            setRsp_q <= RSP_IDLE;
        else if (service && setRsp_q[15:12] != 4'h8)
            setRsp_q <= accessErr ? errCode(reqMulti, 1'b0) : setReq_q;
    end

    // Operation response: link error beats command handling
    logic opAllowed;
    assign opAllowed = service && opRsp_q != REQ_CANCEL
                       && opReq_q != REQ_CANCEL && opReq_q != REQ_STOP
                       && opRsp_q[15:12] != 4'h8;

    always_ff @(posedge clk) begin
        if (!rst_n)
            opRsp_q <= RSP_IDLE;
        else if (lnk_q == LNK_RUN && linkErr && haltOnErr)
            opRsp_q <= RSP_LINK_ERR;
        else if (lnk_q == LNK_HALTED && opReq_q == REQ_CANCEL)
            opRsp_q <= REQ_CANCEL;
        else if (lnk_q == LNK_HALTED && powerBack && powerLoss_q && !proto5)
            opRsp_q <= RSP_IDLE;
        else if (lnk_q == LNK_CANCEL && opReq_q == REQ_STOP)
            opRsp_q <= RSP_IDLE;
        else if (lnk_q == LNK_RUN && opReq_q == REQ_STOP)
            opRsp_q <= RSP_IDLE;
        else if (opAllowed)
            opRsp_q <= accessErr ? errCode(reqMulti, reqBitSpec) : opReq_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            opExecute <= 1'b0;
        else
            opExecute <= opAllowed && !accessErr;
    end

    assign tif.turnDone = service;

    // Read port, data one cycle after strobe
    always_ff @(posedge clk) begin
        if (!rst_n)
            regRdata <= 16'h0000;
        else if (regRd) begin
            unique case (regAddr)
                REG_CTRL:     regRdata <= ctrl_q;
                REG_WAITTIME: regRdata <= wait_q;
                REG_READREQ:  regRdata <= readReq_q;
                REG_SETREQ:   regRdata <= setReq_q;
                REG_OPREQ:    regRdata <= opReq_q;
                REG_READRSP:  regRdata <= readRsp_q;
                REG_SETRSP:   regRdata <= setRsp_q;
                REG_OPRSP:    regRdata <= opRsp_q;
                REG_STATUS:   regRdata <= {8'h00, tif.slot, powerLoss_q,
                                           tif.myTurn, 1'b0, lnk_q};
                default:      regRdata <= 16'h0000;
            endcase
        end else
            regRdata <= 16'h0000;
    end

    assign linkHalted = lnk_q != LNK_RUN;
    assign myTurn     = tif.myTurn;
    assign activeUnit = (highRange ? UNIT_BASE_HIGH : UNIT_BASE_LOW)
                        + {3'h0, tif.slot};
endmodule // plc_link_error_handshake
`default_nettype wire

// ===== tb/plc_partner.sv
// Model of the PLC serial unit and the other gateways on the shared port.
// Assumes the bench starts each exchange or turn pass with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module plc_partner (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bench control
    input  wire logic kick,
    input  wire logic slow,
    input  wire logic passTurn,
    input  wire logic powerOn,
    // PLC pins
    output logic      plcExchange,
    output logic      plcPowerGood,
    output logic      lineToken
);
    logic [3:0] dlyQ;
    logic [3:0] exQ;
    logic [3:0] tokQ;
    always_ff @(posedge clk) begin
        if (!rst_n) dlyQ <= 4'h0;
        else if (kick && powerOn) dlyQ <= slow ? 4'h6 : 4'h1;
        else if (dlyQ != 4'h0) dlyQ <= dlyQ - 4'h1;
    end
    // Held four cycles so the two-flop synchroniser cannot miss it
    always_ff @(posedge clk) begin
        if (!rst_n) exQ <= 4'h0;
        else if (dlyQ == 4'h1 && powerOn) exQ <= 4'h4;
        else if (exQ != 4'h0) exQ <= exQ - 4'h1;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) tokQ <= 4'h0;
        else if (passTurn) tokQ <= 4'h4;
        else if (tokQ != 4'h0) tokQ <= tokQ - 4'h1;
    end
    assign plcExchange  = exQ != 4'h0;
    assign lineToken    = tokQ != 4'h0;
    assign plcPowerGood = powerOn;
endmodule // plc_partner
`default_nettype wire

// ===== tb/plc_link_error_handshake_asserts.sv
// Port-level checks for the link engine.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module plc_link_error_handshake_asserts
    import plc_link_pkg::*;
#(
    parameter int unsigned NT_CYC  = 50,
    parameter int unsigned SEC_CYC = 10,
    parameter int unsigned UNITS   = 32
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst_n,
    // Register port
    input wire logic [3:0]       regAddr,
    input wire logic [15:0]      regWdata,
    input wire logic             regWr,
    input wire logic             regRd,
    input wire logic [15:0]      regRdata,
    // PLC pins
    input wire logic             plcExchange,
    input wire logic             plcPowerGood,
    input wire logic             lineToken,
    // Qualification
    input wire logic [4:0]       reqUnit,
    input wire logic             reqMulti,
    input wire logic             reqBitSpec,
    input wire logic             valueInRange,
    input wire logic             settingLocked,
    input wire logic [UNITS-1:0] unitPresent,
    // Status
    input wire logic             opExecute,
    input wire logic             linkHalted,
    input wire logic             myTurn,
    input wire logic [5:0]       activeUnit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] quietQ;
    logic       cancelQ;
    logic       opReqWr;
    assign opReqWr = regWr && regAddr == REG_OPREQ;
    always_ff @(posedge clk) begin
        if (!rst_n || plcExchange) quietQ <= 8'h00;
        else if (quietQ != 8'hFF) quietQ <= quietQ + 8'h01;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) cancelQ <= 1'b0;
        else if (opReqWr && regWdata == REQ_CANCEL && linkHalted) cancelQ <= 1'b1;
        else if (opReqWr && regWdata == REQ_STOP) cancelQ <= 1'b0;
    end
    halt_quiet_a: assert property ($rose(linkHalted) |-> quietQ >= 8'd25)
        else $error("link halted without a quiet line");
    halt_noexec_a: assert property (linkHalted && $past(linkHalted) |-> !opExecute)
        else $error("operation executed while halted");
    cancel_echo_a: assert property (cancelQ && regRd && regAddr == REG_OPRSP
        |=> regRdata == REQ_CANCEL)
        else $error("cancel not echoed");
    cancel_hold_a: assert property (cancelQ |-> linkHalted)
        else $error("engine running before stop word");
    resume_run_a: assert property (cancelQ && opReqWr && regWdata == REQ_STOP
        |=> ##1 !linkHalted)
        else $error("stop word did not resume engine");
    power_back_a: assert property (linkHalted && !plcPowerGood ##1 plcPowerGood
        |-> ##[1:8] !linkHalted)
        else $error("power return did not clear link error");
    unit_stable_a: assert property ((!plcExchange && !lineToken && !regWr)[*6]
        |=> $stable(activeUnit))
        else $error("active unit moved without cause");
    unit_step_a: assert property ($changed(activeUnit) && !$past(regWr)
        |-> activeUnit[2:0] == $past(activeUnit[2:0]) + 3'd1
            || activeUnit[2:0] == 3'h0)
        else $error("active unit skipped a slot");
    cover property ($rose(linkHalted));
    cover property (opExecute);
    cover property (cancelQ ##1 !cancelQ);
    cover property ($changed(activeUnit));
endmodule // plc_link_error_handshake_asserts
`default_nettype wire

// ===== tb/plc_link_error_handshake_test.sv
// Bench for the link engine: register tasks, PLC model, scripted checks.
// Assumes shortened timeouts through NT_CYC and SEC_CYC.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module plc_link_error_handshake_test
    import plc_link_pkg::*;
;
    localparam int NT = 50;
    logic clk, rst_n, regWr, regRd, kick, slow, passTurn, powerOn;
    logic reqMulti, reqBitSpec, valueInRange, settingLocked, execSeen;
    logic [3:0]  regAddr;
    logic [15:0] regWdata;
    logic [4:0]  reqUnit;
    logic [31:0] unitPresent;
    wire logic [15:0] regRdata;
    wire logic [5:0]  activeUnit;
    wire logic plcExchange, plcPowerGood, lineToken;
    wire logic opExecute, linkHalted, myTurn;
    logic [3:0]  reqA [4];
    logic [3:0]  rspA [4];
    logic [15:0] codeA [4];
    int failCount, checksDone, sinceKick, cyc, n;
    plc_link_error_handshake #(.NT_CYC(NT), .SEC_CYC(10), .UNITS(32))
    u_plc_link_error_handshake (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .plcExchange(plcExchange), .plcPowerGood(plcPowerGood),
        .lineToken(lineToken), .reqUnit(reqUnit), .reqMulti(reqMulti),
        .reqBitSpec(reqBitSpec), .valueInRange(valueInRange),
        .settingLocked(settingLocked), .unitPresent(unitPresent),
        .opExecute(opExecute), .linkHalted(linkHalted), .myTurn(myTurn),
        .activeUnit(activeUnit));
    plc_partner u_plc_partner (.clk(clk), .rst_n(rst_n), .kick(kick),
        .slow(slow), .passTurn(passTurn), .powerOn(powerOn),
        .plcExchange(plcExchange), .plcPowerGood(plcPowerGood),
        .lineToken(lineToken));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        sinceKick <= kick ? 0 : sinceKick + 1;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failCount++;
            wrapUp();
        end
    end
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        `CHK(regRdata, e)
    endtask
    task automatic exch;
        @(posedge clk);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        execSeen = 1'b0;
        repeat (16) begin
            @(negedge clk);
            if (opExecute === 1'b1) execSeen = 1'b1;
        end
    endtask
    task automatic pass;
        @(posedge clk);
        passTurn <= 1'b1;
        @(posedge clk);
        passTurn <= 1'b0;
        repeat (8) @(negedge clk);
    endtask
    // Waits for a halt; n is cycles since the last exchange request
    task automatic waitHalt;
        n = 0;
        while (linkHalted !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        n = sinceKick;
    endtask
    task automatic recover;
        wr(REG_OPREQ, REQ_CANCEL);
        wr(REG_OPREQ, REQ_STOP);
    endtask
    initial begin
        clk = 0; rst_n = 0; regWr = 0; regRd = 0; kick = 0; slow = 0;
        passTurn = 0; powerOn = 1; reqMulti = 0; reqBitSpec = 0;
        valueInRange = 1; settingLocked = 0; regAddr = 0; regWdata = 0;
        reqUnit = 5'd3; unitPresent = 32'hFFFF_FFDF; failCount = 0;
        checksDone = 0; sinceKick = 0; cyc = 0;
        reqA = '{REG_READREQ, REG_SETREQ, REG_OPREQ, REG_OPREQ};
        rspA = '{REG_READRSP, REG_SETRSP, REG_OPRSP, REG_OPRSP};
        codeA = '{RSP_ERR_SINGLE, RSP_ERR_MULTI, RSP_ERR_BIT_S, RSP_ERR_BIT_M};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chk(REG_CTRL, CTRL_RESET);
        chk(REG_WAITTIME, WAIT_RESET);
        wr(4'hC, 16'h5A5A);
        chk(4'hC, 16'h0000);
        `CHK(activeUnit, 6'h00)
        for (int i = 0; i < 4; i++) begin
            reqMulti <= i[0];
            reqBitSpec <= i[1];
            valueInRange <= (i == 1 || i == 2);
            settingLocked <= (i == 1);
            reqUnit <= (i == 2) ? 5'd5 : 5'd3;
            wr(reqA[i], 16'h0011);
            exch();
            chk(rspA[i], codeA[i]);
            valueInRange <= 1'b1;
            settingLocked <= 1'b0;
            reqUnit <= 5'd3;
            exch();
            chk(rspA[i], codeA[i]);
            wr(reqA[i], REQ_STOP);
            exch();
            chk(rspA[i], RSP_IDLE);
            wr(reqA[i], 16'h0022);
            exch();
            `CHK(execSeen, (i > 1))
            chk(rspA[i], 16'h0022);
            wr(reqA[i], REQ_STOP);
        end
        exch();
        waitHalt();
        `CHK(n >= NT && n <= NT + 8, 1'b1)
        chk(REG_OPRSP, RSP_LINK_ERR);
        wr(REG_OPREQ, 16'h0001);
        exch();
        `CHK(execSeen, 1'b0)
        wr(REG_OPREQ, REQ_CANCEL);
        chk(REG_OPRSP, REQ_CANCEL);
        wr(REG_READREQ, 16'h0066);
        exch();
        chk(REG_READRSP, 16'h0066);
        `CHK(execSeen, 1'b0)
        wr(REG_OPREQ, REQ_STOP);
        chk(REG_OPRSP, RSP_IDLE);
        `CHK(linkHalted, 1'b0)
        wr(REG_WAITTIME, 16'h0001);
        wr(REG_CTRL, 16'h0001);
        exch();
        waitHalt();
        `CHK(n >= 30 && n <= 42, 1'b1)
        chk(REG_OPRSP, RSP_LINK_ERR);
        recover();
        wr(REG_CTRL, 16'h0002);
        exch();
        waitHalt();
        `CHK(linkHalted, 1'b0)
        chk(REG_OPRSP, RSP_IDLE);
        wr(REG_CTRL, 16'h0006);
        exch();
        waitHalt();
        `CHK(linkHalted, 1'b1)
        recover();
        wr(REG_CTRL, CTRL_RESET);
        exch();
        powerOn <= 1'b0;
        waitHalt();
        `CHK(linkHalted, 1'b1)
        powerOn <= 1'b1;
        repeat (8) @(negedge clk);
        `CHK(linkHalted, 1'b0)
        chk(REG_OPRSP, RSP_IDLE);
        wr(REG_CTRL, 16'h0020);
        `CHK(myTurn, 1'b1)
        wr(REG_READREQ, 16'h0077);
        exch();
        chk(REG_READRSP, 16'h0077);
        `CHK(activeUnit, 6'h01)
        `CHK(myTurn, 1'b0)
        wr(REG_READREQ, 16'h0088);
        slow <= 1'b1;
        exch();
        chk(REG_READRSP, 16'h0077);
        pass();
        `CHK(activeUnit, 6'h02)
        pass();
        `CHK(activeUnit, 6'h00)
        `CHK(myTurn, 1'b1)
        wr(REG_CTRL, 16'h0028);
        `CHK(activeUnit, 6'h20)
        wrapUp();
    end
endmodule // plc_link_error_handshake_test
bind plc_link_error_handshake plc_link_error_handshake_asserts #(
    .NT_CYC(NT_CYC), .SEC_CYC(SEC_CYC), .UNITS(UNITS)) u_chk (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .plcExchange(plcExchange), .plcPowerGood(plcPowerGood),
    .lineToken(lineToken), .reqUnit(reqUnit), .reqMulti(reqMulti),
    .reqBitSpec(reqBitSpec), .valueInRange(valueInRange),
    .settingLocked(settingLocked), .unitPresent(unitPresent),
    .opExecute(opExecute), .linkHalted(linkHalted), .myTurn(myTurn),
    .activeUnit(activeUnit));
`default_nettype wire
